// [rtl/posted_pending_irq_controller.sv]
// Contract
// R1: each source sets a sticky posted flag, held until taken or cleared.
// R2: pending equals posted and mask; only pending feeds the encoder.
// R3: clearing a mask bit keeps posted flags and still allows posting.
// R4: encoder gives highest-priority pending vector; taken only with global enable.
// R5: priority order and vectors 04h to 20h, step four, sleep lowest.
// R6: request goes active on event, mask enabling posted flag, or enable rising.
// R7: core finishes current instruction before interrupt entry.
// R8: core entry takes 13 cycles pushing pc high, pc low, flags.
// R9: core clears its flags, including global enable, after pushing.
// R10: core loads pc low byte with vector presented by controller.
// R11: return pops flags, pc low, pc high, restoring global enable.
// R12: remaining pending requests are serviced before the next normal instruction; here the registered request lets one core cycle run after return first.
// R13: latency is instruction remainder plus entry plus 7-cycle long jump.
// R14: handler may re-enable global enable; software guards the stack.
// R15: posted-clear read returns all posted flags.
// R16: soft-post off: written zero clears flag, written one ignored.
// R17: soft-post on: written zero ignored, written one posts the flag.
// R18: posted-clear bit order two-wire, sleep, serial, port, timer, touch, analog, supply.
// R19: software writes zero to reserved bits.
// R20: software should clear a posted flag before enabling its block.
// R21: vector-clear read returns winning vector byte, or 00h when idle.
// R22: any write to vector-clear clears all posted and pending interrupts.
// R23: mask register uses posted-clear bit order and resets to zero.
// R24: soft-post enable is bit 0 at its register, reset zero.
// R25: hardware post and clear in one cycle leave the flag posted.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module posted_pending_irq_controller #(
    parameter int NSRC = irq_ctrl_pkg::NUM_SRC
) (
    input  wire logic             CLOCK,
    input  wire logic             RST,
    // source condition pulses, same clock domain
    input  wire logic [NSRC-1:0]  SRC_EVENT,
    // core side
    input  wire logic             GLOBAL_IRQ_ENABLE,
    input  wire logic             IRQ_ACK,
    output logic                  IRQ_REQ,
    output logic [7:0]            IRQ_VECTOR,
    // axi4-lite slave
    input  wire logic [11:0]      S_AXI_AWADDR,
    input  wire logic             S_AXI_AWVALID,
    output logic                  S_AXI_AWREADY,
    input  wire logic [31:0]      S_AXI_WDATA,
    input  wire logic [3:0]       S_AXI_WSTRB,
    input  wire logic             S_AXI_WVALID,
    output logic                  S_AXI_WREADY,
    output logic [1:0]            S_AXI_BRESP,
    output logic                  S_AXI_BVALID,
    input  wire logic             S_AXI_BREADY,
    input  wire logic [11:0]      S_AXI_ARADDR,
    input  wire logic             S_AXI_ARVALID,
    output logic                  S_AXI_ARREADY,
    output logic [31:0]           S_AXI_RDATA,
    output logic [1:0]            S_AXI_RRESP,
    output logic                  S_AXI_RVALID,
    input  wire logic             S_AXI_RREADY
);

    logic [NSRC-1:0] posted_r;
    logic [NSRC-1:0] posted_nxt;
    logic [NSRC-1:0] mask_r;
    logic            soft_post_r;
    logic [NSRC-1:0] pending;
    logic [7:0]      win_vec;
    logic [11:0]     aw_addr_r;
    logic            aw_have_r;
    logic [7:0]      w_data_r;
    logic            w_lane0_r;
    logic            w_have_r;
    logic            wr_fire;
    logic [NSRC-1:0] take_clr;

    // vector for a given source bit; bit order is not priority order
    function automatic logic [7:0] vec_of(input int b);
        case (b)
            irq_ctrl_pkg::BIT_SUPPLY:  vec_of = irq_ctrl_pkg::VEC_SUPPLY;
            irq_ctrl_pkg::BIT_ANALOG:  vec_of = irq_ctrl_pkg::VEC_ANALOG;
            irq_ctrl_pkg::BIT_TOUCH:   vec_of = irq_ctrl_pkg::VEC_TOUCH;
            irq_ctrl_pkg::BIT_TIMER:   vec_of = irq_ctrl_pkg::VEC_TIMER;
            irq_ctrl_pkg::BIT_PORT:    vec_of = irq_ctrl_pkg::VEC_PORT;
            irq_ctrl_pkg::BIT_SERIAL:  vec_of = irq_ctrl_pkg::VEC_SERIAL;
            irq_ctrl_pkg::BIT_TWOWIRE: vec_of = irq_ctrl_pkg::VEC_TWOWIRE;
            irq_ctrl_pkg::BIT_SLEEP:   vec_of = irq_ctrl_pkg::VEC_SLEEP;
            default:                   vec_of = irq_ctrl_pkg::VEC_NONE;
        endcase
    endfunction

    // a masked-off flag never reaches the encoder
    assign pending = posted_r & mask_r; // see R2, see R3, see R23

    // smallest vector wins; reset vector 00h doubles as "nothing pending"
    always_comb
    begin
        win_vec = irq_ctrl_pkg::VEC_NONE;
        for (int i = 0; i < NSRC; i++)
        begin
            if (pending[i] && (win_vec == irq_ctrl_pkg::VEC_NONE || vec_of(i) < win_vec))
            begin
                win_vec = vec_of(i); // see R4, see R5
            end
        end
    end

    // the acknowledge removes the pending source whose vector equals IRQ_VECTOR in the acknowledge cycle
    always_comb
    begin
        take_clr = '0;
        for (int i = 0; i < NSRC; i++)
        begin
            take_clr[i] = IRQ_ACK && pending[i] && (vec_of(i) == IRQ_VECTOR); // see R1, see R10
        end
    end

    // a write is committed once both address and data are held
    assign wr_fire = aw_have_r && w_have_r && !S_AXI_BVALID;

    // posted flag next state; hardware post beats every clear in the same cycle
    always_comb
    begin
        posted_nxt = posted_r & ~take_clr;
        if (wr_fire && w_lane0_r && aw_addr_r == irq_ctrl_pkg::ADDR_POSTED_CLEAR)
        begin
            if (soft_post_r)
            begin
                posted_nxt = posted_nxt | w_data_r[NSRC-1:0]; // see R17
            end
            else
            begin
                posted_nxt = posted_nxt & w_data_r[NSRC-1:0]; // see R16, see R18
            end
        end
        if (wr_fire && aw_addr_r == irq_ctrl_pkg::ADDR_VECTOR_CLEAR)
        begin
            posted_nxt = '0; // see R22
        end
        posted_nxt = posted_nxt | SRC_EVENT; // see R1, see R3, see R25
    end

    // posted flags
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            posted_r <= irq_ctrl_pkg::RST_POSTED[NSRC-1:0];
        end
        else
        begin
            posted_r <= posted_nxt;
        end
    end

    // mask and soft-post enable, written only through byte lane 0
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            mask_r      <= irq_ctrl_pkg::RST_MASK[NSRC-1:0];
            soft_post_r <= irq_ctrl_pkg::RST_SOFT_POST;
        end
        else if (wr_fire && w_lane0_r)
        begin
            if (aw_addr_r == irq_ctrl_pkg::ADDR_SOURCE_MASK)
            begin
                mask_r <= w_data_r[NSRC-1:0]; // see R23
            end
            if (aw_addr_r == irq_ctrl_pkg::ADDR_SOFT_POST_EN)
            begin
                soft_post_r <= w_data_r[irq_ctrl_pkg::SOFT_POST_BIT]; // see R24
            end
        end
    end

    // request to the core; registered, so a new event shows one cycle after posting.
    // gating by global enable makes a 0->1 enable edge raise the request one cycle later
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            IRQ_REQ    <= 1'b0;
            IRQ_VECTOR <= irq_ctrl_pkg::VEC_NONE;
        end
        else
        begin
            IRQ_REQ    <= GLOBAL_IRQ_ENABLE && (|pending); // see R4, see R6, see R12
            IRQ_VECTOR <= win_vec; // see R10, see R21
        end
    end

    // write address channel; held until the response is accepted
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            aw_have_r     <= 1'b0;
            aw_addr_r     <= '0;
            S_AXI_AWREADY <= 1'b0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_have_r && !S_AXI_AWREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                aw_have_r <= 1'b0;
            end
        end
    end

    // write data channel; only the low lane carries register bits
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            w_have_r     <= 1'b0;
            w_data_r     <= '0;
            w_lane0_r    <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end
        else
        begin
            S_AXI_WREADY <= !w_have_r && !S_AXI_WREADY;
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_have_r  <= 1'b1;
                w_data_r  <= S_AXI_WDATA[7:0];
                w_lane0_r <= S_AXI_WSTRB[0];
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                w_have_r <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= irq_ctrl_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            S_AXI_BVALID <= 1'b1;
            case (aw_addr_r)
                irq_ctrl_pkg::ADDR_POSTED_CLEAR,
                irq_ctrl_pkg::ADDR_SOURCE_MASK,
                irq_ctrl_pkg::ADDR_SOFT_POST_EN,
                irq_ctrl_pkg::ADDR_VECTOR_CLEAR: S_AXI_BRESP <= irq_ctrl_pkg::RESP_OKAY;
                default:                         S_AXI_BRESP <= irq_ctrl_pkg::RESP_SLVERR;
            endcase
        end
        else if (S_AXI_BREADY)
        begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // read channel; arready only while no read data is waiting
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= irq_ctrl_pkg::RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && !(S_AXI_ARVALID && S_AXI_ARREADY);
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= irq_ctrl_pkg::RESP_OKAY;
                S_AXI_RDATA  <= '0;
                case (S_AXI_ARADDR)
                    irq_ctrl_pkg::ADDR_POSTED_CLEAR: S_AXI_RDATA[NSRC-1:0] <= posted_r; // see R15
                    irq_ctrl_pkg::ADDR_SOURCE_MASK:  S_AXI_RDATA[NSRC-1:0] <= mask_r;
                    irq_ctrl_pkg::ADDR_SOFT_POST_EN: S_AXI_RDATA[0] <= soft_post_r;
                    irq_ctrl_pkg::ADDR_VECTOR_CLEAR: S_AXI_RDATA[7:0] <= win_vec; // see R21
                    default:                         S_AXI_RRESP <= irq_ctrl_pkg::RESP_SLVERR;
                endcase
            end
            else if (S_AXI_RREADY)
            begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// [pkg/irq_ctrl_pkg.sv]
`default_nettype none
package irq_ctrl_pkg;
    // register indices (printed offsets are not multiples of four); byte address = 4 * index
    localparam logic [7:0] IDX_POSTED_CLEAR = 8'hda;
    localparam logic [7:0] IDX_SOURCE_MASK  = 8'he0;
    localparam logic [7:0] IDX_SOFT_POST_EN = 8'he1;
    localparam logic [7:0] IDX_VECTOR_CLEAR = 8'he2;
    localparam int         ADDR_W           = 12;
    localparam logic [11:0] ADDR_POSTED_CLEAR = {2'b00, IDX_POSTED_CLEAR, 2'b00};
    localparam logic [11:0] ADDR_SOURCE_MASK  = {2'b00, IDX_SOURCE_MASK, 2'b00};
    localparam logic [11:0] ADDR_SOFT_POST_EN = {2'b00, IDX_SOFT_POST_EN, 2'b00};
    localparam logic [11:0] ADDR_VECTOR_CLEAR = {2'b00, IDX_VECTOR_CLEAR, 2'b00};
    // reset values
    localparam logic [7:0] RST_POSTED       = 8'h00;
    localparam logic [7:0] RST_MASK         = 8'h00;
    localparam logic       RST_SOFT_POST    = 1'b0;
    // field positions
    localparam int         SOFT_POST_BIT    = 0;
    // source bit positions in the posted/mask registers
    localparam int         BIT_SUPPLY  = 0;
    localparam int         BIT_ANALOG  = 1;
    localparam int         BIT_TOUCH   = 2;
    localparam int         BIT_TIMER   = 3;
    localparam int         BIT_PORT    = 4;
    localparam int         BIT_SERIAL  = 5;
    localparam int         BIT_SLEEP   = 6;
    localparam int         BIT_TWOWIRE = 7;
    localparam int         NUM_SRC     = 8;
    // vectors
    localparam logic [7:0] VEC_NONE    = 8'h00;
    localparam logic [7:0] VEC_SUPPLY  = 8'h04;
    localparam logic [7:0] VEC_ANALOG  = 8'h08;
    localparam logic [7:0] VEC_TOUCH   = 8'h0c;
    localparam logic [7:0] VEC_TIMER   = 8'h10;
    localparam logic [7:0] VEC_PORT    = 8'h14;
    localparam logic [7:0] VEC_SERIAL  = 8'h18;
    localparam logic [7:0] VEC_TWOWIRE = 8'h1c;
    localparam logic [7:0] VEC_SLEEP   = 8'h20;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// [verif/irq_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker #(
    parameter int NSRC = 8
) (
    input wire logic            CLOCK,
    input wire logic            RST,
    input wire logic [NSRC-1:0] SRC_EVENT,
    input wire logic            GLOBAL_IRQ_ENABLE,
    input wire logic            IRQ_ACK,
    input wire logic            IRQ_REQ,
    input wire logic [7:0]      IRQ_VECTOR,
    input wire logic [11:0]     S_AXI_AWADDR,
    input wire logic            S_AXI_AWVALID,
    input wire logic            S_AXI_AWREADY,
    input wire logic            S_AXI_WVALID,
    input wire logic            S_AXI_WREADY,
    input wire logic [11:0]     S_AXI_ARADDR,
    input wire logic            S_AXI_ARVALID,
    input wire logic            S_AXI_ARREADY,
    input wire logic [31:0]     S_AXI_RDATA,
    input wire logic [1:0]      S_AXI_RRESP,
    input wire logic            S_AXI_RVALID
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic ar_take;
    logic wr_vc;
    logic ar_bad;
    logic quiet;
    // bus takes and quiet source lines, decoded once
    assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    assign wr_vc = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
                   && S_AXI_AWADDR == irq_ctrl_pkg::ADDR_VECTOR_CLEAR;
    assign ar_bad = !(S_AXI_ARADDR inside {irq_ctrl_pkg::ADDR_POSTED_CLEAR,
        irq_ctrl_pkg::ADDR_SOURCE_MASK, irq_ctrl_pkg::ADDR_SOFT_POST_EN,
        irq_ctrl_pkg::ADDR_VECTOR_CLEAR});
    assign quiet = SRC_EVENT == '0;

    chk_req_enable: assert property (IRQ_REQ |-> $past(GLOBAL_IRQ_ENABLE))
        else $error("request raised without global enable");
    chk_vec_legal: assert property (IRQ_VECTOR[1:0] == 2'b00 && IRQ_VECTOR <= 8'h20)
        else $error("vector outside the table");
    chk_req_vector: assert property (IRQ_REQ |-> IRQ_VECTOR != irq_ctrl_pkg::VEC_NONE)
        else $error("request with empty vector");
    // a write in flight may legally clear, so only idle-bus cycles are judged
    chk_req_sticky: assert property (IRQ_REQ && GLOBAL_IRQ_ENABLE && !IRQ_ACK
        && S_AXI_AWREADY && !S_AXI_AWVALID |=> IRQ_REQ) else $error("request lost");
    chk_vc_read: assert property (ar_take && S_AXI_ARADDR == irq_ctrl_pkg::ADDR_VECTOR_CLEAR
        |=> S_AXI_RVALID && S_AXI_RDATA == {24'h0, IRQ_VECTOR}) else $error("vector read");
    chk_vc_clear: assert property (quiet ##1 (wr_vc && quiet) ##1 quiet[*3]
        |=> IRQ_VECTOR == irq_ctrl_pkg::VEC_NONE && !IRQ_REQ) else $error("clear-all failed");
    chk_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_unmapped_read: assert property (ar_take && ar_bad |=> S_AXI_RVALID
        && S_AXI_RRESP == irq_ctrl_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read answer");

    cov_clear_all: cover property (wr_vc);
    cov_taken: cover property (IRQ_ACK);
    cov_two_wire: cover property (IRQ_REQ && IRQ_VECTOR == irq_ctrl_pkg::VEC_TWOWIRE);
endmodule

bind posted_pending_irq_controller irq_ctrl_checker #(.NSRC(NSRC)) u_chk (
    .CLOCK(CLOCK), .RST(RST), .SRC_EVENT(SRC_EVENT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID));
`default_nettype wire

// [verif/cpu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model #(
    parameter int ENTRY_CYC = 13,
    parameter int JUMP_CYC  = 7,
    parameter int ISR_CYC   = 20
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       irq_req,
    input  wire logic [7:0] irq_vector,
    input  wire logic       run_en,
    output logic            irq_ack,
    output logic            global_irq_enable,
    output logic [7:0]      last_vec,
    output logic [3:0]      n_taken
);
    int busy_r;
    // flags stay cleared through entry and handler, restored on return;
    // the handler never re-enables, so nesting and its stack risk stay out
    assign global_irq_enable = run_en && (busy_r == 0);
    // one cycle stands for one instruction, so every cycle is a boundary
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_r   <= 0;
            irq_ack  <= 1'b0;
            last_vec <= 8'h00;
            n_taken  <= 4'h0;
        end
        else
        begin
            irq_ack <= 1'b0;
            if (busy_r != 0)
                busy_r <= busy_r - 1;
            else if (irq_req && global_irq_enable)
            begin
                irq_ack  <= 1'b1;
                last_vec <= irq_vector;
                n_taken  <= n_taken + 4'h1;
                busy_r   <= ENTRY_CYC + JUMP_CYC + ISR_CYC;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  src_event = 8'h00;
    logic        run_en = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, global_irq_enable, ack, req;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  vec, last_vec, left;
    logic [3:0]  n_taken;
    int          n_errors = 0, cmp_count = 0, cycles = 0;
    int          src_bit [8] = '{0, 1, 2, 3, 4, 5, 7, 6};

    posted_pending_irq_controller DUT (
        .CLOCK(clk), .RST(rst), .SRC_EVENT(src_event), .GLOBAL_IRQ_ENABLE(global_irq_enable),
        .IRQ_ACK(ack), .IRQ_REQ(req), .IRQ_VECTOR(vec), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    cpu_core_model core (.clk(clk), .rst(rst), .irq_req(req), .irq_vector(vec),
        .run_en(run_en), .irq_ack(ack), .global_irq_enable(global_irq_enable), .last_vec(last_vec), .n_taken(n_taken));

    always #12.5 clk = ~clk;

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (bvalid !== 1'b1) @(posedge clk);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, irq_ctrl_pkg::RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rdata, exp);
    endtask

    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        src_event <= m;
        @(posedge clk);
        src_event <= 8'h00;
        repeat (2) @(posedge clk);
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("MISMATCH t=%0t timeout", $time);
            final_report();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_chk(irq_ctrl_pkg::ADDR_POSTED_CLEAR, 32'h0);
        rd_chk(irq_ctrl_pkg::ADDR_SOURCE_MASK, 32'h0);
        rd_chk(irq_ctrl_pkg::ADDR_SOFT_POST_EN, 32'h0);
        rd_chk(12'h004, 32'h0);
        $display("test reset_values done");
        pulse(8'hff);
        rd_chk(irq_ctrl_pkg::ADDR_POSTED_CLEAR, 32'hff);
        rd_chk(irq_ctrl_pkg::ADDR_VECTOR_CLEAR, 32'h0);
        axi_wr(irq_ctrl_pkg::ADDR_SOURCE_MASK, 8'hff);
        left = 8'hff;
        // winner walks down the priority table as each flag is cleared
        for (int i = 0; i < 8; i++)
        begin
            rd_chk(irq_ctrl_pkg::ADDR_VECTOR_CLEAR, 32'((i + 1) * 4));
            left &= ~(8'h01 << src_bit[i]);
            axi_wr(irq_ctrl_pkg::ADDR_POSTED_CLEAR, ~(8'h01 << src_bit[i]));
            rd_chk(irq_ctrl_pkg::ADDR_POSTED_CLEAR, {24'h0, left});
        end
        $display("test priority done");
        axi_wr(irq_ctrl_pkg::ADDR_SOFT_POST_EN, 8'h01);
        axi_wr(irq_ctrl_pkg::ADDR_POSTED_CLEAR, 8'h28);
        axi_wr(irq_ctrl_pkg::ADDR_POSTED_CLEAR, 8'h00);
        rd_chk(irq_ctrl_pkg::ADDR_POSTED_CLEAR, 32'h28);
        rd_chk(irq_ctrl_pkg::ADDR_VECTOR_CLEAR, 32'h10);
        axi_wr(irq_ctrl_pkg::ADDR_VECTOR_CLEAR, 8'h5a);
        rd_chk(irq_ctrl_pkg::ADDR_POSTED_CLEAR, 32'h0);
        axi_wr(irq_ctrl_pkg::ADDR_SOFT_POST_EN, 8'h00);
        $display("test soft_post done");
        axi_wr(irq_ctrl_pkg::ADDR_SOURCE_MASK, 8'h88);
        pulse(8'h88);
        check({31'h0, req}, 32'h0);
        run_en <= 1'b1;
        while (n_taken < 4'h1) @(posedge clk);
        check({24'h0, last_vec}, 32'h10);
        while (n_taken < 4'h2) @(posedge clk);
        check({24'h0, last_vec}, 32'h1c);
        rd_chk(irq_ctrl_pkg::ADDR_POSTED_CLEAR, 32'h0);
        $display("test core_entry done");
        final_report();
    end
endmodule
`default_nettype wire
